//--- inc/epp_pkg.sv
// Purpose: Shared constants for the EPROM programming port block
// Assumes: 8K x 8 array, byte-wide programming port pins
// Notes: All pin inputs are synchronised inside the top module
package epp_pkg;
  localparam int EPP_AW = 13;
  localparam int EPP_DW = 8;
  localparam int EPP_DEPTH = 8192;
  localparam int EPP_MSB = 7;
  localparam int EPP_SEL_BIT = 4;
  localparam int EPP_PV_BIT = 6;
  localparam logic [7:0] EPP_ERASED = 8'hFF;
  localparam logic EPP_LOCK_OPEN = 1'b1;
  // Pin decoder modes
  typedef enum logic [2:0] {
    EPP_M_IDLE,
    EPP_M_PROG,
    EPP_M_VERIFY,
    EPP_M_PROTECT,
    EPP_M_PVERIFY
  } epp_mode_t;
endpackage : epp_pkg

//--- logic/epp_mode_dec.sv
// Purpose: Decodes the programming pin levels into one mode
// Assumes: Inputs are already synchronised to i_mclk
// Notes: Purely combinational
module epp_mode_dec
  import epp_pkg::*;
(
  input wire logic i_cs_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_test_sel,
  input wire logic i_sel_a4,
  input wire logic i_sel_a6,
  output epp_mode_t o_mode
);
  // Protect needs all strobes high plus high test select
  wire prot = i_test_sel && i_cs_n && i_oe_n && i_we_n && i_sel_a4;
  wire pver = i_test_sel && !i_cs_n && !i_oe_n && i_we_n && !i_sel_a6;
  wire prog = !i_test_sel && !i_cs_n && i_oe_n && !i_we_n;
  wire vrfy = !i_test_sel && !i_cs_n && !i_oe_n && i_we_n;
  assign o_mode = prot ? EPP_M_PROTECT :
                  pver ? EPP_M_PVERIFY :
                  prog ? EPP_M_PROG :
                  vrfy ? EPP_M_VERIFY : EPP_M_IDLE;
endmodule : epp_mode_dec

//--- logic/epp_core.sv
// Purpose: On-chip EPROM programming port with readout lock
// Assumes: Programmer drives pins asynchronously; one 200 MHz clock
// Notes: Cells only move from one to zero; erase is a separate input
module epp_core
  import epp_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic i_ce,
  input wire logic i_erase,
  input wire logic [12:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic i_cs_n,
  input wire logic i_oe_n,
  input wire logic i_write_strobe_n,
  input wire logic i_test_mode_select,
  input wire logic [15:0] i_internal_program_path,
  input wire logic i_prog_to_ext,
  input wire logic i_mac_ext_fetch,
  output logic [7:0] o_device_data_pins,
  output logic [7:0] o_device_data_oe,
  output logic o_readout_lock_cell,
  output logic o_micro_mode_en,
  output logic [15:0] o_ext_bus,
  output logic o_ext_bus_en,
  output logic o_mac_ext_fetch_ok
);
  // ----------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------
  localparam int SW = EPP_AW + EPP_DW + 5;
  // Idle pin levels: strobes high, test select and erase low
  localparam logic [SW-1:0] SYNC_IDLE = {13'h0000, EPP_ERASED, 3'h7, 2'h0};
  logic [SW-1:0] s1_q, s2_q;
  wire [SW-1:0] pin_raw = {i_addr, i_data, i_cs_n, i_oe_n,
    i_write_strobe_n, i_test_mode_select, i_erase};
  // Two flops on every pin; reset to idle so no false erase or protect
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      s1_q <= SYNC_IDLE;
      s2_q <= SYNC_IDLE;
    end
    else if (i_ce)
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end
  wire [12:0] a = s2_q[25:13];
  wire [7:0] d = s2_q[12:5];
  wire cs_n = s2_q[4];
  wire oe_n = s2_q[3];
  wire we_n = s2_q[2];
  wire tsel = s2_q[1];
  wire erase = s2_q[0];

  // ----------------------------------------------------
  // Mode decode
  // ----------------------------------------------------
  epp_mode_t mode;
  epp_mode_dec u_dec (
    .i_cs_n(cs_n),
    .i_oe_n(oe_n),
    .i_we_n(we_n),
    .i_test_sel(tsel),
    .i_sel_a4(a[EPP_SEL_BIT]),
    .i_sel_a6(a[EPP_PV_BIT]),
    .o_mode(mode)
  );

  // ----------------------------------------------------
  // Array and lock cell
  // ----------------------------------------------------
  logic [7:0] mem [EPP_DEPTH];
  logic lock_q;
  logic [7:0] rd_q;
  logic [12:0] clr_q;
  logic clr_busy_q;
  logic q8_q;
  wire q8_fall = q8_q && !d[EPP_MSB];
  // Write strobe active, select and test select low, output enable high: cell programs; else inhibited
  wire do_prog = (mode == EPP_M_PROG) && !clr_busy_q;
  wire do_lock = (mode == EPP_M_PROTECT) && q8_fall;
  // Program: clear bits only, any address order
  always_ff @(posedge i_mclk)
  begin
    if (i_ce)
    begin
      if (clr_busy_q)
        mem[clr_q] <= EPP_ERASED;
      else if (do_prog)
        mem[a] <= mem[a] & d;
      rd_q <= mem[a];
    end
  end
  // Erase sweep; only erase reopens the lock
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      clr_busy_q <= 1'b0;
      clr_q <= '0;
      q8_q <= 1'b1;
    end
    else if (i_ce)
    begin
      q8_q <= d[EPP_MSB];
      if (erase && !clr_busy_q)
      begin
        clr_busy_q <= 1'b1;
        clr_q <= '0;
      end
      else if (clr_busy_q)
      begin
        clr_q <= clr_q + 13'h1;
        if (clr_q == 13'(EPP_DEPTH - 1))
          clr_busy_q <= 1'b0;
      end
    end
  end
  // Lock cell is nonvolatile: reset leaves it; erase alone opens it
  always_ff @(posedge i_mclk)
  begin
    if (i_ce)
    begin
      if (erase)
        lock_q <= EPP_LOCK_OPEN;
      else if (do_lock)
        lock_q <= ~EPP_LOCK_OPEN;
    end
  end
  wire locked = (lock_q != EPP_LOCK_OPEN);

  // ----------------------------------------------------
  // Data pin drive
  // ----------------------------------------------------
  // Read and verify share pin levels, so both close while locked
  wire rd_en = (mode == EPP_M_VERIFY) && !locked;
  wire pv_en = (mode == EPP_M_PVERIFY);
  logic [7:0] dout_d, oe_d;
  assign dout_d = pv_en ? {lock_q, 7'h00} : rd_q;
  assign oe_d = pv_en ? 8'h80 : (rd_en ? 8'hFF : 8'h00);
  // Registered pin outputs, released when select or enable high
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_device_data_pins <= 8'h00;
      o_device_data_oe <= 8'h00;
    end
    else if (i_ce)
    begin
      o_device_data_pins <= dout_d;
      o_device_data_oe <= (cs_n || oe_n) ? 8'h00 : oe_d;
    end
  end

  // ----------------------------------------------------
  // Program path merge onto external bus
  // ----------------------------------------------------
  // Lock cuts the program path at the merge; nodes go unused
  always_ff @(posedge i_mclk)
  begin
    if (i_reset)
    begin
      o_ext_bus <= 16'h0000;
      o_ext_bus_en <= 1'b0;
      o_readout_lock_cell <= EPP_LOCK_OPEN;
      o_micro_mode_en <= 1'b1;
      o_mac_ext_fetch_ok <= 1'b0;
    end
    else if (i_ce)
    begin
      o_ext_bus_en <= i_prog_to_ext && !locked;
      o_ext_bus <= locked ? 16'h0000 : i_internal_program_path;
      o_readout_lock_cell <= lock_q;
      o_micro_mode_en <= !locked;
      o_mac_ext_fetch_ok <= i_mac_ext_fetch && !locked;
    end
  end

  // ----------------------------------------------------
  // Checks
  // ----------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  prog_inhibit_a: assert property (i_ce && (cs_n || we_n)
    |-> !do_prog)
    else $error("array write while inhibited");
  out_release_a: assert property (i_ce && (cs_n || oe_n)
    |=> o_device_data_oe == 8'h00)
    else $error("data pins driven while released");
  lock_block_a: assert property (i_ce && locked
    && mode == EPP_M_VERIFY |=> o_device_data_oe == 8'h00)
    else $error("read allowed while locked");
  lock_hold_a: assert property (i_ce && locked && !erase
    |=> locked)
    else $error("lock cleared without erase");
  micro_off_a: assert property (i_ce && locked
    |=> !o_micro_mode_en && !o_ext_bus_en)
    else $error("micro mode or bus left on");
  pverify_a: assert property (i_ce && mode == EPP_M_PVERIFY
    |=> o_device_data_oe == 8'h80
    && o_device_data_pins[7] == $past(lock_q))
    else $error("protect verify wrong");
  mac_block_a: assert property (i_ce && locked
    |=> !o_mac_ext_fetch_ok)
    else $error("mac fetch while locked");
  lock_set_a: assert property (i_ce && do_lock && !erase
    |=> locked)
    else $error("lock did not set");
  read_drive_a: assert property (i_ce && !locked
    && mode == EPP_M_VERIFY |=> o_device_data_oe == 8'hFF)
    else $error("verify not driven");
  read_c: cover property (mode == EPP_M_VERIFY && !locked);
  prog_c: cover property (do_prog);
  lock_c: cover property (do_lock);
  pv_c: cover property (pv_en && locked);
endmodule : epp_core

//--- verif/epp_prog_model.sv
// Purpose: Byte-wide EPROM programmer model driving the port pins
// Assumes: Pins change on falling clock edges only
// Notes: Pulse length is a parameter, shortened by the bench
module epp_prog_model
  import epp_pkg::*;
#(
  parameter int PULSE_CYC = 20000,
  parameter int MAX_TRY = 10,
  parameter int PRIME_CYC = 200000,
  parameter int MAX_PRIME = 25
)
(
  input wire logic i_mclk,
  input wire logic [7:0] i_pins,
  input wire logic [7:0] i_pins_oe,
  output logic [12:0] o_addr,
  output logic [7:0] o_data,
  output logic o_cs_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_test_sel,
  output logic o_pass,
  output logic [12:0] o_fail_addr
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle levels: deselected, no strobes
  initial
  begin
    {o_cs_n, o_oe_n, o_we_n, o_test_sel} = 4'hE;
    o_addr = 13'h0000;
    o_data = 8'hFF;
    o_pass = 1'b0;
    o_fail_addr = 13'h0000;
  end
  // ---------------------------------------------
  // Pin cycles, control order is cs, oe, we, test
  // ---------------------------------------------
  task automatic pins(input logic [3:0] c, input logic [12:0] a,
                      input logic [7:0] d, input int n);
    @(negedge i_mclk);
    {o_cs_n, o_oe_n, o_we_n, o_test_sel} = c;
    o_addr = a;
    o_data = c[2] ? d : ~o_data; // Released lines show inverse
    repeat (n) @(negedge i_mclk);
  endtask : pins
  // Held read, then back to idle
  task automatic rd(input logic [3:0] c, input logic [12:0] a,
                    output logic [7:0] q, output logic [7:0] e);
    pins(c, a, 8'hFF, 8);
    q = i_pins;
    e = i_pins_oe;
    pins(4'hE, a, 8'hFF, 2);
  endtask : rd
  // Pulse and verify loop with retry limit
  task automatic prog_byte(input logic [12:0] a, input logic [7:0] d);
    o_pass = 1'b0;
    for (int k = 0; k < MAX_TRY && !o_pass; k++)
    begin
      pins(4'h6, a, d, 4);
      pins(4'h4, a, d, PULSE_CYC);
      pins(4'h6, a, d, 2);
      pins(4'h2, a, d, 8);
      o_pass = (i_pins === d) && (i_pins_oe === 8'hFF);
    end
    if (!o_pass)
      o_fail_addr = a;
    pins(4'hE, a, d, 2);
  endtask : prog_byte
  // Long prime pulses, then one final pulse three times their total
  task automatic prog_byte_long(input logic [12:0] a, input logic [7:0] d);
    int k;
    o_pass = 1'b0;
    for (k = 0; k < MAX_PRIME && !o_pass; k++)
    begin
      pins(4'h6, a, d, 4);
      pins(4'h4, a, d, PRIME_CYC);
      pins(4'h6, a, d, 2);
      pins(4'h2, a, d, 8);
      o_pass = (i_pins === d) && (i_pins_oe === 8'hFF);
    end
    if (o_pass)
    begin
      pins(4'h6, a, d, 4);
      pins(4'h4, a, d, 3 * k * PRIME_CYC);
    end
    else
      o_fail_addr = a;
    pins(4'hE, a, d, 2);
  endtask : prog_byte_long
  // Word as two bytes, low first
  task automatic prog_word(input logic [12:0] a, input logic [15:0] w);
    prog_byte(a, w[7:0]);
    prog_byte(a + 13'h0001, w[15:8]);
  endtask : prog_word
  // Lock cell: strobes and A4 high, top line pulsed low
  task automatic lock_cell();
    pins(4'hF, 13'h0010, 8'hFF, 4);
    pins(4'hF, 13'h0010, 8'h7F, 8);
    pins(4'hF, 13'h0010, 8'hFF, 4);
    pins(4'hE, 13'h0000, 8'hFF, 2);
  endtask : lock_cell
endmodule : epp_prog_model

//--- verif/eprom_program_protect_modes_bench.sv
// Purpose: Self-checking bench for the EPROM programming port
// Assumes: Short programming pulses stand in for long ones
// Notes: Both erase sweeps dominate the run time
module eprom_program_protect_modes_bench
  import epp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 1'b0, reset = 1'b1, ce = 1'b1, erase = 1'b0;
  logic p2e = 1'b0, macf = 1'b0;
  logic [12:0] addr, fail_addr;
  logic [7:0] data, pins, pins_oe, q, e;
  logic cs_n, oe_n, we_n, tsel, pass, lock, micro, ext_en, mac_ok;
  logic [15:0] ext_bus;
  int n_mismatch = 0, n_checks = 0, n_cyc = 0;
  always #2.5 mclk = ~mclk;
  epp_core u_epp_core (.i_mclk(mclk), .i_reset(reset), .i_ce(ce),
    .i_erase(erase), .i_addr(addr), .i_data(data), .i_cs_n(cs_n),
    .i_oe_n(oe_n), .i_write_strobe_n(we_n), .i_test_mode_select(tsel),
    .i_internal_program_path(16'h1234), .i_prog_to_ext(p2e),
    .i_mac_ext_fetch(macf), .o_device_data_pins(pins),
    .o_device_data_oe(pins_oe), .o_readout_lock_cell(lock),
    .o_micro_mode_en(micro), .o_ext_bus(ext_bus), .o_ext_bus_en(ext_en),
    .o_mac_ext_fetch_ok(mac_ok));
  epp_prog_model #(.PULSE_CYC(8), .PRIME_CYC(8)) u_epp_prog_model (
    .i_mclk(mclk),
    .i_pins(pins), .i_pins_oe(pins_oe), .o_addr(addr), .o_data(data),
    .o_cs_n(cs_n), .o_oe_n(oe_n), .o_we_n(we_n), .o_test_sel(tsel),
    .o_pass(pass), .o_fail_addr(fail_addr));
  // ------------------
  // Checks and closing
  // ------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic do_erase(input string s);
    erase = 1'b1;
    repeat (4) @(negedge mclk);
    erase = 1'b0;
    repeat (8200) @(negedge mclk);
    $display("test %s finished", s);
  endtask : do_erase
  // Hang guard
  always @(posedge mclk)
  begin
    n_cyc++;
    if (n_cyc == 40000)
    begin
      n_mismatch++;
      wrap_up();
    end
  end
  // Main sequence
  initial
  begin
    repeat (2) @(negedge mclk);
    chk(micro, 16'h0001);
    chk(pins_oe, 16'h0000);
    reset = 1'b0;
    @(negedge mclk);
    chk(pins_oe, 16'h0000);
    do_erase("erase");
    chk({lock, micro}, 16'h0003);
    u_epp_prog_model.prog_word(13'h1A54, 16'hA53C);
    chk(pass, 16'h0001);
    u_epp_prog_model.prog_byte(13'h0002, 8'hC3);
    chk(pass, 16'h0001);
    u_epp_prog_model.rd(4'h2, 13'h1A54, q, e);
    chk({q, e}, 16'h3CFF);
    u_epp_prog_model.rd(4'h2, 13'h1A55, q, e);
    chk({q, e}, 16'hA5FF);
    u_epp_prog_model.pins(4'hC, 13'h0002, 8'h00, 12);
    u_epp_prog_model.rd(4'h2, 13'h0002, q, e);
    chk({q, e}, 16'hC3FF);
    u_epp_prog_model.rd(4'h8, 13'h0002, q, e);
    chk(e, 16'h0000);
    u_epp_prog_model.rd(4'h6, 13'h0002, q, e);
    chk(e, 16'h0000);
    u_epp_prog_model.prog_byte(13'h0002, 8'h3C);
    chk({pass, fail_addr}, 16'h0002);
    u_epp_prog_model.prog_byte_long(13'h0100, 8'h5A);
    chk(pass, 16'h0001);
    u_epp_prog_model.rd(4'h2, 13'h0100, q, e);
    chk({q, e}, 16'h5AFF);
    $display("test program finished");
    p2e = 1'b1;
    macf = 1'b1;
    repeat (4) @(negedge mclk);
    chk({ext_en, mac_ok}, 16'h0003);
    chk(ext_bus, 16'h1234);
    u_epp_prog_model.rd(4'h3, 13'h0000, q, e);
    chk({q[7], e}, 16'h0180);
    u_epp_prog_model.lock_cell();
    chk({lock, micro}, 16'h0000);
    u_epp_prog_model.rd(4'h3, 13'h0000, q, e);
    chk({q[7], e}, 16'h0080);
    u_epp_prog_model.rd(4'h2, 13'h1A55, q, e);
    chk(e, 16'h0000);
    chk({ext_en, mac_ok}, 16'h0000);
    reset = 1'b1;
    repeat (2) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    chk(lock, 16'h0000);
    $display("test lock finished");
    do_erase("unlock");
    chk({lock, micro}, 16'h0003);
    wrap_up();
  end
endmodule : eprom_program_protect_modes_bench
